/* File: hw/ddw_top.v */
// Serial write control of a dual 8-bit converter.
`include "ddw_map.vh"

module ddw_top (
  sys_clk, // System clock, 200 MHz
  resetn, // Asynchronous reset, active low
  frame_sel_n, // Frame select pin, active low
  sclk, // Serial clock pin
  din, // Serial data pin
  channel_a_output, // Channel A output code
  channel_b_output, // Channel B output code
  out_mode, // Output mode: active or termination
  frame_done, // Pulse: valid frame executed
  frame_abort, // Pulse: partial frame abandoned
  frame_active, // Level: frame being received
  last_op // Operation of the last valid frame
);
  input wire sys_clk; // System clock, 200 MHz
  input wire resetn; // Asynchronous reset, active low
  input wire frame_sel_n; // Frame select pin, active low
  input wire sclk; // Serial clock pin
  input wire din; // Serial data pin
  output reg [`DDW_CODE_W-1:0] channel_a_output; // Channel A output code
  output reg [`DDW_CODE_W-1:0] channel_b_output; // Channel B output code
  output reg [1:0] out_mode; // Output mode: active or termination
  output reg frame_done; // Pulse: valid frame executed
  output reg frame_abort; // Pulse: partial frame abandoned
  output reg frame_active; // Level: frame being received
  output reg [1:0] last_op; // Operation of the last valid frame

  // Frame states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  // Maps a termination select to the shown output mode
  function [1:0] term_mode;
    input [1:0] term;
    begin
      case (term)
        `DDW_TERM_HIZ_LO: term_mode = `DDW_MODE_HIZ;
        `DDW_TERM_2K5: term_mode = `DDW_MODE_2K5;
        `DDW_TERM_100K: term_mode = `DDW_MODE_100K;
        `DDW_TERM_HIZ_HI: term_mode = `DDW_MODE_HIZ;
        default: term_mode = `DDW_MODE_HIZ;
      endcase
    end
  endfunction

  // Bit counter step, cut to counter width
  function [`DDW_CNT_W-1:0] cnt_inc;
    input [`DDW_CNT_W-1:0] cnt;
    begin
      cnt_inc = cnt + `DDW_CNT_ONE;
    end
  endfunction

  // New code for the addressed channel, held code for the other
  function [`DDW_CODE_W-1:0] pick_code;
    input hit;
    input [`DDW_CODE_W-1:0] new_code;
    input [`DDW_CODE_W-1:0] old_code;
    begin
      if (hit) begin
        pick_code = new_code;
      end else begin
        pick_code = old_code;
      end
    end
  endfunction

  // Synchronised pins
  wire [`DDW_PIN_W-1:0] pins_s;
  wire fs_n_s;
  wire sck_s;
  wire din_s;

  ddw_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pins_async({frame_sel_n, sclk, din}),
    .pins_sync(pins_s)
  );

  assign fs_n_s = pins_s[`DDW_PIN_FS];
  assign sck_s = pins_s[`DDW_PIN_SCK];
  assign din_s = pins_s[`DDW_PIN_DIN];

  // Serial clock edge finder, reads the synchronised copy only
  reg sck_prev_q;
  wire sck_fall;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  assign sck_fall = sck_prev_q & ~sck_s;

  // Frame sequencer
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`DDW_CNT_W-1:0] cnt_q;
  reg [`DDW_CNT_W-1:0] cnt_d;
  reg [`DDW_WORD_W-1:0] shift_q;
  reg [`DDW_WORD_W-1:0] shift_d;
  reg exec_d;
  reg abort_d;
  wire [`DDW_WORD_W-1:0] word_next;

  // Word as it stands after the bit of this edge
  assign word_next = {shift_q[`DDW_WORD_W-2:0], din_s};

  // Counter shows that this fall carries the sixteenth bit
  wire last_bit;
  assign last_bit = (cnt_q == `DDW_CNT_LAST);

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    exec_d = 1'b0;
    abort_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // Open on frame select low; an edge here is not taken
        if (!fs_n_s) begin
          state_d = ST_SHIFT;
          cnt_d = `DDW_CNT_ZERO;
        end
      end
      ST_SHIFT: begin
        if (fs_n_s) begin
          state_d = ST_IDLE;
          abort_d = 1'b1;
        end else if (sck_fall) begin
          shift_d = word_next;
          cnt_d = cnt_inc(cnt_q);
          if (last_bit) begin
            state_d = ST_DONE;
            exec_d = 1'b1;
          end
        end
      end
      ST_DONE: begin
        // Clocks and data ignored until frame select rises
        if (fs_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= `DDW_CNT_ZERO;
      shift_q <= `DDW_WORD_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
    end
  end

  // Command fields of the word completing on this edge
  wire dec_chan_b;
  wire [1:0] dec_op;
  wire [`DDW_CODE_W-1:0] dec_code;
  wire [1:0] dec_term;

  ddw_decode u_decode (
    .word(word_next),
    .chan_b(dec_chan_b),
    .op(dec_op),
    .code(dec_code),
    .term(dec_term)
  );

  // Channel hold registers and power-down state
  reg [`DDW_CODE_W-1:0] hold_a_q;
  reg [`DDW_CODE_W-1:0] hold_a_d;
  reg [`DDW_CODE_W-1:0] hold_b_q;
  reg [`DDW_CODE_W-1:0] hold_b_d;
  reg [`DDW_CODE_W-1:0] out_a_d;
  reg [`DDW_CODE_W-1:0] out_b_d;
  reg [1:0] mode_d;
  reg [1:0] last_op_d;

  // Hold values after a single-channel load of this word
  wire [`DDW_CODE_W-1:0] load_a;
  wire [`DDW_CODE_W-1:0] load_b;

  assign load_a = pick_code(~dec_chan_b, dec_code, hold_a_q);
  assign load_b = pick_code(dec_chan_b, dec_code, hold_b_q);

  always @* begin
    hold_a_d = hold_a_q;
    hold_b_d = hold_b_q;
    out_a_d = channel_a_output;
    out_b_d = channel_b_output;
    mode_d = out_mode;
    last_op_d = last_op;
    // Nothing moves except on a completed frame
    if (exec_d) begin
      last_op_d = dec_op;
      case (dec_op)
        `DDW_OP_LOAD: begin
          hold_a_d = load_a;
          hold_b_d = load_b;
          mode_d = `DDW_MODE_ACTIVE;
        end
        `DDW_OP_LOAD_UPD: begin
          hold_a_d = load_a;
          hold_b_d = load_b;
          // Both outputs take the hold values, new one included
          out_a_d = load_a;
          out_b_d = load_b;
          mode_d = `DDW_MODE_ACTIVE;
        end
        `DDW_OP_LOAD_BOTH: begin
          hold_a_d = dec_code;
          hold_b_d = dec_code;
          out_a_d = dec_code;
          out_b_d = dec_code;
          mode_d = `DDW_MODE_ACTIVE;
        end
        `DDW_OP_PDOWN: begin
          // Codes kept so the outputs resume on wake-up
          mode_d = term_mode(dec_term);
        end
        default: begin
          mode_d = out_mode;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_a_q <= `DDW_CODE_RST;
      hold_b_q <= `DDW_CODE_RST;
      channel_a_output <= `DDW_CODE_RST;
      channel_b_output <= `DDW_CODE_RST;
      out_mode <= `DDW_MODE_ACTIVE;
      last_op <= `DDW_OP_LOAD;
    end else begin
      hold_a_q <= hold_a_d;
      hold_b_q <= hold_b_d;
      channel_a_output <= out_a_d;
      channel_b_output <= out_b_d;
      out_mode <= mode_d;
      last_op <= last_op_d;
    end
  end

  // Status pulses and frame level
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_done <= 1'b0;
      frame_abort <= 1'b0;
      frame_active <= 1'b0;
    end else begin
      frame_done <= exec_d;
      frame_abort <= abort_d;
      frame_active <= (state_d == ST_SHIFT);
    end
  end
endmodule // ddw_top

/* File: pkg/ddw_map.vh */
// Constants for the dual converter serial write control.
`ifndef DDW_MAP_VH
`define DDW_MAP_VH

// Serial command word layout
`define DDW_WORD_W 16
`define DDW_CNT_W 5
`define DDW_CNT_ZERO 5'h00
`define DDW_CNT_ONE 5'h01
`define DDW_CNT_LAST 5'h0F
`define DDW_LEAD_BIT 15
`define DDW_SEL_BIT 14
`define DDW_OPH_BIT 13
`define DDW_OPL_BIT 12
`define DDW_CODE_MSB 11
`define DDW_CODE_LSB 4
`define DDW_TERM_MSB 15
`define DDW_TERM_LSB 14
`define DDW_WORD_RST 16'h0000

// Channel code
`define DDW_CODE_W 8
`define DDW_CODE_RST 8'h00

// Operation codes
`define DDW_OP_LOAD 2'h0
`define DDW_OP_LOAD_UPD 2'h1
`define DDW_OP_LOAD_BOTH 2'h2
`define DDW_OP_PDOWN 2'h3

// Termination codes carried in the first two command bits
`define DDW_TERM_HIZ_LO 2'h0
`define DDW_TERM_2K5 2'h1
`define DDW_TERM_100K 2'h2
`define DDW_TERM_HIZ_HI 2'h3

// Output mode shown on the status port
`define DDW_MODE_ACTIVE 2'h0
`define DDW_MODE_HIZ 2'h1
`define DDW_MODE_2K5 2'h2
`define DDW_MODE_100K 2'h3

// Pin synchroniser width: frame select, serial clock, data
`define DDW_PIN_W 3
`define DDW_PIN_FS 2
`define DDW_PIN_SCK 1
`define DDW_PIN_DIN 0
`define DDW_PIN_RST 3'h4

`endif

/* File: hw/ddw_sync.v */
// Two-stage synchroniser for the three serial link pins.
`include "ddw_map.vh"

module ddw_sync (
  sys_clk, // System clock
  resetn, // Asynchronous reset, active low
  pins_async, // Raw link pins
  pins_sync // Synchronised pins
);
  input wire sys_clk; // System clock
  input wire resetn; // Asynchronous reset, active low
  input wire [`DDW_PIN_W-1:0] pins_async; // Raw link pins
  output wire [`DDW_PIN_W-1:0] pins_sync; // Synchronised pins

  reg [`DDW_PIN_W-1:0] meta_q;
  reg [`DDW_PIN_W-1:0] sync_q;

  // Frame select resets high so no frame is seen at release
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= `DDW_PIN_RST;
      sync_q <= `DDW_PIN_RST;
    end else begin
      meta_q <= pins_async;
      sync_q <= meta_q;
    end
  end

  assign pins_sync = sync_q;
endmodule // ddw_sync

/* File: hw/ddw_decode.v */
// Field decoder for a complete serial command word.
`include "ddw_map.vh"

module ddw_decode (
  word, // Complete command word
  chan_b, // Channel select, high for channel B
  op, // Operation code
  code, // Channel code
  term // Termination select
);
  input wire [`DDW_WORD_W-1:0] word; // Complete command word
  output wire chan_b; // Channel select, high for channel B
  output wire [1:0] op; // Operation code
  output wire [`DDW_CODE_W-1:0] code; // Channel code
  output wire [1:0] term; // Termination select

  assign chan_b = word[`DDW_SEL_BIT];
  assign op = {word[`DDW_OPH_BIT], word[`DDW_OPL_BIT]};
  // Upper eight payload bits, MSB first, trailing four dropped
  assign code = word[`DDW_CODE_MSB:`DDW_CODE_LSB];
  assign term = word[`DDW_TERM_MSB:`DDW_TERM_LSB];
endmodule // ddw_decode

/* File: sim/ddw_top_properties.sv */
// Checker of the serial write control outputs.
`include "ddw_map.vh"
module ddw_top_props (
  input logic sys_clk, // System clock
  input logic resetn, // Reset, active low
  input logic [7:0] channel_a_output, // Code A
  input logic [7:0] channel_b_output, // Code B
  input logic [1:0] out_mode, // Output mode
  input logic frame_done, // Done pulse
  input logic frame_abort, // Abort pulse
  input logic frame_active, // Shifting
  input logic [1:0] last_op // Last operation
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Shifting ends in a done or abort pulse
  sequence end_s;
    ##[0:2] (frame_done || frame_abort);
  endsequence
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("done pulse too long");
  change_on_done_a: assert property (!frame_done |-> $stable({channel_a_output,
    channel_b_output, out_mode})) else $error("outputs moved without a frame");
  abort_keeps_a: assert property (frame_abort |-> !frame_done && $stable({channel_a_output,
    channel_b_output, out_mode, last_op})) else $error("abort changed state");
  frame_end_a: assert property ($fell(frame_active) |-> end_s)
    else $error("frame end without pulse");
  done_after_a: assert property (frame_done |-> !frame_active && $past(frame_active, 3))
    else $error("done without shifting");
  down_mode_a: assert property (frame_done && last_op == `DDW_OP_PDOWN |->
    out_mode != `DDW_MODE_ACTIVE && $stable({channel_a_output, channel_b_output}))
    else $error("power-down wrong");
  wake_mode_a: assert property (frame_done && last_op != `DDW_OP_PDOWN |->
    out_mode == `DDW_MODE_ACTIVE) else $error("not active after load");
  hold_load_a: assert property (frame_done && last_op == `DDW_OP_LOAD |->
    $stable({channel_a_output, channel_b_output})) else $error("load moved outputs");
  both_load_a: assert property (frame_done && last_op == `DDW_OP_LOAD_BOTH |->
    channel_a_output == channel_b_output) else $error("both load differs");
  reset_zero_a: assert property ($rose(resetn) |-> {channel_a_output,
    channel_b_output, out_mode, last_op} == 20'h00000) else $error("reset not zero");
endmodule // ddw_top_props
bind ddw_top ddw_top_props ddw_top_props_inst (.sys_clk(sys_clk), .resetn(resetn),
  .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
  .out_mode(out_mode), .frame_done(frame_done), .frame_abort(frame_abort),
  .frame_active(frame_active), .last_op(last_op));

/* File: sim/ddw_host.sv */
// Host model driving the three-wire write link.
module ddw_host (
  output logic frame_sel_n, // Frame select, active low
  output logic sclk, // Serial clock
  output logic din // Serial data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Sends n bits MSB first; bits past 16 repeat the word
  task automatic send(input logic [15:0] w, input int n);
    #7.3 frame_sel_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = w[15 - i % 16];
      #24 sclk = 1'b0;
      #24;
    end
    din = 1'b0;
    frame_sel_n = 1'b1;
    #40;
  endtask
endmodule // ddw_host

/* File: sim/tb.sv */
// Self-checking bench for the serial write control.
`include "ddw_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, resetn, frame_sel_n, sclk, din, frame_done, frame_abort, frame_active;
  logic [7:0] channel_a_output, channel_b_output, hold_a, hold_b, exp_a, exp_b;
  logic [1:0] out_mode, last_op, exp_m;
  logic [19:0] q[$];
  logic [31:0] rng = 32'h0000001E;
  int miscompares = 0, compares = 0, aborts = 0, seen_aborts = 0;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ddw_top ddw_top_inst (.sys_clk(sys_clk), .resetn(resetn), .frame_sel_n(frame_sel_n),
    .sclk(sclk), .din(din), .channel_a_output(channel_a_output),
    .channel_b_output(channel_b_output), .out_mode(out_mode), .frame_done(frame_done),
    .frame_abort(frame_abort), .frame_active(frame_active), .last_op(last_op));
  ddw_host ddw_host_inst (.frame_sel_n(frame_sel_n), .sclk(sclk), .din(din));
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic check(input string n, input logic [19:0] e, input logic [19:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] op, sel, input logic [7:0] c, input int n);
    logic [1:0] s;
    s = (op == `DDW_OP_PDOWN) ? sel : {1'b0, sel[0]};
    if (op == `DDW_OP_PDOWN) begin
      exp_m = (s == 2'h1) ? `DDW_MODE_2K5 : (s == 2'h2) ? `DDW_MODE_100K : `DDW_MODE_HIZ;
    end else begin
      exp_m = `DDW_MODE_ACTIVE;
      if (op == `DDW_OP_LOAD_BOTH) {hold_a, hold_b} = {c, c};
      else if (s[0]) hold_b = c;
      else hold_a = c;
      if (op != `DDW_OP_LOAD) {exp_a, exp_b} = {hold_a, hold_b};
    end
    q.push_back({exp_a, exp_b, exp_m, op});
    ddw_host_inst.send({s, op, c, rng[11:8]}, n);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Results are compared once they have settled after the edge
  always @(posedge sys_clk) begin
    #1;
    if (frame_abort === 1'b1) seen_aborts++;
    if (frame_done === 1'b1) begin
      if (q.size() == 0) check("spare frame", 20'h00000, 20'hFFFFF);
      else check("frame", q.pop_front(), {channel_a_output, channel_b_output, out_mode, last_op});
    end
  end
  initial begin
    #60000;
    miscompares++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    {hold_a, hold_b, exp_a, exp_b} = 32'h00000000;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    check("reset", 20'h00000, {channel_a_output, channel_b_output, out_mode, last_op});
    repeat (5) @(negedge sys_clk);
    wr(`DDW_OP_LOAD, 2'h0, 8'hFF, 16);
    wr(`DDW_OP_LOAD_UPD, 2'h1, 8'h00, 16);
    wr(`DDW_OP_LOAD_BOTH, 2'h0, rnd(), 20);
    wr(`DDW_OP_LOAD, 2'h1, rnd(), 16);
    for (int t = 0; t < 4; t++) begin
      wr(`DDW_OP_PDOWN, t[1:0], rnd(), 16);
    end
    aborts++;
    ddw_host_inst.send({4'h2, 12'hABC}, 9);
    wr(`DDW_OP_LOAD, 2'h0, rnd(), 16);
    wr(`DDW_OP_LOAD_UPD, 2'h1, rnd(), 17);
    for (int i = 0; i < 8; i++) begin
      void'(rnd());
      wr(rng[9:8], rng[11:10], rng[7:0], 16 + rng[13:12]);
    end
    @(negedge sys_clk);
    resetn = 1'b0;
    {hold_a, hold_b, exp_a, exp_b} = 32'h00000000;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    check("reset again", 20'h00000, {channel_a_output, channel_b_output, out_mode, last_op});
    repeat (5) @(negedge sys_clk);
    wr(`DDW_OP_LOAD_UPD, 2'h1, 8'h5A, 16);
    #200;
    check("aborts", 20'(aborts), 20'(seen_aborts));
    check("left over", 20'h00000, 20'(q.size()));
    end_of_test();
  end
endmodule // tb
